// >>> hdl/flash_seq_regs.svh
// register offsets, field positions, reset values and timing constants
// for the flash erase and row program sequencer; definitions only
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// byte offsets on the plain register port
`define OFS_FLASH_OP_CONTROL   8'h00
`define OFS_FLASH_UNLOCK_KEY   8'h04
`define OFS_TABLE_PAGE_POINTER 8'h08
`define OFS_TARGET_OFFSET      8'h0c
`define OFS_ROW_BUFFER         8'h10

// flash_op_control fields
`define CTL_OP_LSB    0
`define CTL_OP_MSB    3
`define CTL_ERASE_BIT 6
`define CTL_GATE_BIT  14
`define CTL_START_BIT 15
`define CTL_RESET     16'h0000

// operation select codes
`define OP_PAGE_ERASE 4'h2
`define OP_ROW_PROG   4'h1

// unlock keys
`define KEY_FIRST  16'h0055
`define KEY_SECOND 16'h00aa

// geometry in instruction words
`define ROW_WORDS_DEF  64
`define PAGE_ROWS      8

// timing: figures in ns, cycles derived from the clock period
`define CLK_PERIOD_NS  8
`define ERASE_TIME_NS  20000
`define PROG_TIME_NS   8000

`endif

// >>> hdl/flash_seq_pkg.sv
// types shared by the flash erase and row program sequencer
// assumes the register header is included by the design file
`default_nettype none
package flash_seq_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_XFER  = 3'b010,
    ST_WAIT  = 3'b011
  } seq_state_t;

endpackage : flash_seq_pkg

`default_nettype wire

// >>> hdl/flash_page_erase_row_program.sv
// flash sequencer: unlock, page erase and row programming of program flash
// assumes a synchronous register master and a timed flash array port
//
// How it works
// - programming writes exactly one row per operation
// - erase clears one whole eight-row page
// - select code 0010 means page erase
// - select code 0001 means row programming
// - bit 6 marks erase, clear for programming
// - write-enable gate bit 14 required to start
// - start accepted only after correct unlock keys
// - start bit begins erase, processor stalls throughout
// - start bit runs row program, processor stalls
// - start bit self-clears when cycle completes
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"

module flash_page_erase_row_program
  import flash_seq_pkg::*;
#(
  parameter int ROW_WORDS = `ROW_WORDS_DEF,
  parameter int CNT_W     = 16,
  parameter int ERASE_CYC = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1)
                            / `CLK_PERIOD_NS,
  parameter int PROG_CYC  = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1)
                            / `CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             cpu_stall,
  output logic             flash_erase,
  output logic             flash_prog_wr,
  output logic      [23:0] flash_addr,
  output logic      [15:0] flash_wdata
);

  localparam int IDX_W = $clog2(ROW_WORDS);
  localparam int PAGE_W = IDX_W + $clog2(`PAGE_ROWS);

  // refuse geometry and counts the logic cannot serve
  if (ROW_WORDS < 2 || (1 << IDX_W) != ROW_WORDS || PAGE_W > 16)
    $error("ROW_WORDS must be a power of two, page within 16 bits");
  if (ERASE_CYC < 1 || PROG_CYC < 1 || ERASE_CYC >= (1 << CNT_W)
      || PROG_CYC >= (1 << CNT_W))
    $error("timing counts must fit in CNT_W bits and be nonzero");

  // clear the low address bits below a block of 2**w words
  function automatic logic [23:0] align_down(input logic [23:0] a,
                                             input int w);
    logic [23:0] m;
    m = 24'hffffff << w;
    return a & m;
  endfunction : align_down

  seq_state_t         state_q, state_d;
  logic [3:0]         op_q;
  logic               erase_q, gate_q, start_q;
  logic               key_half_q, armed_q;
  logic [7:0]         page_q;
  logic [15:0]        offs_q;
  logic [IDX_W-1:0]   fill_q, xfer_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [15:0]        row_mem [ROW_WORDS];

  // address decode
  wire sel_ctl  = (reg_addr == `OFS_FLASH_OP_CONTROL);
  wire sel_key  = (reg_addr == `OFS_FLASH_UNLOCK_KEY);
  wire sel_page = (reg_addr == `OFS_TABLE_PAGE_POINTER);
  wire sel_offs = (reg_addr == `OFS_TARGET_OFFSET);
  wire sel_buf  = (reg_addr == `OFS_ROW_BUFFER);
  wire idle     = (state_q == ST_IDLE);
  wire wr_ctl   = reg_wr & sel_ctl & idle;
  wire wr_key   = reg_wr & sel_key;
  wire wr_buf   = reg_wr & sel_buf & idle;

  // requested operation, checked for a consistent code and erase flag
  wire [3:0] req_op    = reg_wdata[`CTL_OP_MSB:`CTL_OP_LSB];
  wire       req_erase = reg_wdata[`CTL_ERASE_BIT];
  wire       req_gate  = reg_wdata[`CTL_GATE_BIT];
  wire       req_start = reg_wdata[`CTL_START_BIT];
  wire is_erase = (req_op == `OP_PAGE_ERASE) & req_erase;
  wire is_prog  = (req_op == `OP_ROW_PROG) & ~req_erase;
  wire go = wr_ctl & req_start & req_gate & armed_q
            & (is_erase | is_prog);
  wire last_cnt = (cnt_q == CNT_W'(1));
  wire [23:0] target = {page_q, offs_q};

  // control register; start bit held until the cycle ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_q    <= 4'(`CTL_RESET);
      erase_q <= 1'b0;
      gate_q  <= 1'b0;
      start_q <= 1'b0;
    end else if (wr_ctl) begin
      op_q    <= req_op;
      erase_q <= req_erase;
      gate_q  <= req_gate;
      start_q <= go;
    end else if (state_q == ST_WAIT && last_cnt) begin
      start_q <= 1'b0;
    end
  end

  // unlock: 55h then AAh as consecutive key writes, consumed by control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_half_q <= 1'b0;
      armed_q    <= 1'b0;
    end else if (wr_key) begin
      key_half_q <= (reg_wdata == `KEY_FIRST);
      armed_q    <= key_half_q & (reg_wdata == `KEY_SECOND);
    end else if (wr_ctl) begin
      key_half_q <= 1'b0;
      armed_q    <= 1'b0;
    end
  end

  // page pointer and in-page offset of the target
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_q <= 8'h00;
      offs_q <= 16'h0000;
    end else if (reg_wr & idle) begin
      if (sel_page) page_q <= reg_wdata[7:0];
      if (sel_offs) offs_q <= reg_wdata;
    end
  end

  // holding buffer fill pointer, rewound after each row
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) fill_q <= '0;
    else if (wr_buf) fill_q <= fill_q + IDX_W'(1);
    else if (state_q == ST_XFER && xfer_q == IDX_W'(ROW_WORDS - 1))
      fill_q <= '0;
  end

  // holding buffer storage
  always_ff @(posedge clk) begin
    if (wr_buf) row_mem[fill_q] <= reg_wdata;
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (go) state_d = is_erase ? ST_ERASE : ST_XFER;
      ST_ERASE: state_d = ST_WAIT;
      ST_XFER:  if (xfer_q == IDX_W'(ROW_WORDS - 1)) state_d = ST_WAIT;
      ST_WAIT:  if (last_cnt) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // state, word index and busy-time counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      xfer_q  <= '0;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_XFER) xfer_q <= xfer_q + IDX_W'(1);
      if (state_q == ST_ERASE) cnt_q <= CNT_W'(ERASE_CYC);
      else if (state_q == ST_XFER) cnt_q <= CNT_W'(PROG_CYC);
      else if (state_q == ST_WAIT) cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // flash array strobes, address and data, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flash_erase   <= 1'b0;
      flash_prog_wr <= 1'b0;
      flash_addr    <= 24'h000000;
      flash_wdata   <= 16'h0000;
    end else begin
      flash_erase   <= (state_q == ST_ERASE);
      flash_prog_wr <= (state_q == ST_XFER);
      if (state_q == ST_ERASE)
        flash_addr <= align_down(target, PAGE_W);
      else if (state_q == ST_XFER)
        flash_addr <= align_down(target, IDX_W)
                      | {{(24-IDX_W){1'b0}}, xfer_q};
      if (state_q == ST_XFER) flash_wdata <= row_mem[xfer_q];
    end
  end

  // processor held off while the start bit stands
  assign cpu_stall = start_q;

  // read mux; start bit shows the busy state
  wire [15:0] ctl_view = {start_q, gate_q, 7'h00, erase_q, 2'h0, op_q};
  wire [15:0] rd_mux =
      sel_ctl  ? ctl_view :
      sel_page ? {8'h00, page_q} :
      sel_offs ? offs_q :
      sel_buf  ? 16'(fill_q) : 16'h0000;

  // read data in the cycle after the strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 16'h0000;
    else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // helper: words emitted in the current row
  logic [IDX_W:0] words_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) words_q <= '0;
    else if (idle) words_q <= '0;
    else if (flash_prog_wr) words_q <= words_q + (IDX_W+1)'(1);
  end

  a_start_needs_key: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) |-> $past(armed_q))
    else $error("start accepted without unlock");
  a_start_needs_gate: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) |-> gate_q)
    else $error("start without write-enable gate");
  a_erase_op_code: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) && erase_q |-> op_q == `OP_PAGE_ERASE)
    else $error("erase started with wrong code");
  a_prog_op_code: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) && !erase_q |-> op_q == `OP_ROW_PROG)
    else $error("program started with wrong code");
  a_erase_flag_path: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) |-> (erase_q ? state_q == ST_ERASE : state_q == ST_XFER))
    else $error("erase flag does not steer operation");
  a_erase_page_strobe: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) && erase_q |=> flash_erase
      && flash_addr[PAGE_W-1:0] == '0)
    else $error("page erase strobe missing or misaligned");
  a_row_word_count: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(start_q) && !erase_q |-> words_q == (IDX_W+1)'(ROW_WORDS))
    else $error("row program did not write one full row");
  a_stall_while_busy: assert property (
    @(posedge clk) disable iff (!rstn)
    !idle |-> cpu_stall && start_q)
    else $error("processor not stalled during cycle");
  a_start_self_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_WAIT && last_cnt |=> !start_q && idle)
    else $error("start bit not cleared at completion");
  a_busy_reads_one: assert property (
    @(posedge clk) disable iff (!rstn)
    reg_rd && sel_ctl && start_q |=> reg_rdata[`CTL_START_BIT])
    else $error("start bit not visible while busy");
  a_key_cancel: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_key && reg_wdata != `KEY_SECOND |=> !armed_q)
    else $error("stray key write left unlock armed");
  a_key_pair_arms: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_key && key_half_q && reg_wdata == `KEY_SECOND |=> armed_q)
    else $error("back to back keys did not arm");
  a_locked_no_start: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_ctl && !armed_q |=> !start_q && idle)
    else $error("control write started while locked");
  a_prog_first_word: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(start_q) && !erase_q |=> flash_prog_wr
      && flash_addr[IDX_W-1:0] == '0)
    else $error("row program did not begin at word zero");
  a_erase_hold_time: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_ERASE |=> state_q == ST_WAIT
      && cnt_q == CNT_W'(ERASE_CYC))
    else $error("erase busy time not loaded");
  a_prog_hold_time: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_XFER && xfer_q == IDX_W'(ROW_WORDS - 1) |=>
      state_q == ST_WAIT && cnt_q == CNT_W'(PROG_CYC))
    else $error("program busy time not loaded");

  c_page_erase: cover property (@(posedge clk) disable iff (!rstn)
    $rose(start_q) && erase_q);
  c_row_prog: cover property (@(posedge clk) disable iff (!rstn)
    $fell(start_q) && !erase_q);
  c_locked_start: cover property (@(posedge clk) disable iff (!rstn)
    wr_ctl && req_start && !armed_q);
  c_key_cancel: cover property (@(posedge clk) disable iff (!rstn)
    wr_key && key_half_q && reg_wdata != `KEY_SECOND);

endmodule : flash_page_erase_row_program

`default_nettype wire

// >>> tb/flash_array_model.sv
// flash array stand-in: counts erases and word writes, keeps the last ones
// assumes registered one-cycle pulses from the sequencer, no handshake
`timescale 1ns/100ps
`default_nettype none

module flash_array_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        flash_erase,
  input  wire logic        flash_prog_wr,
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_wdata,
  output var  int          erase_cnt,
  output var  int          prog_cnt,
  output logic      [23:0] erase_addr,
  output logic      [23:0] prog_addr,
  output logic      [15:0] prog_data
);
  // record each access in the cycle its pulse stands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      erase_cnt  <= 0;
      prog_cnt   <= 0;
      erase_addr <= 24'h000000;
      prog_addr  <= 24'h000000;
      prog_data  <= 16'h0000;
    end else begin
      if (flash_erase === 1'b1) begin
        erase_cnt  <= erase_cnt + 1;
        erase_addr <= flash_addr;
      end
      if (flash_prog_wr === 1'b1) begin
        prog_cnt  <= prog_cnt + 1;
        prog_addr <= flash_addr;
        prog_data <= flash_wdata;
      end
    end
  end
endmodule : flash_array_model

`default_nettype wire

// >>> tb/flash_page_erase_row_program_tb.sv
// bench: register-port driver, unlock, erase and row program sequences
// assumes the register header and package are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"

module flash_page_erase_row_program_tb;
  logic        clk, rstn, reg_wr, reg_rd, cpu_stall;
  logic        flash_erase, flash_prog_wr;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, flash_wdata, prog_data;
  logic [23:0] flash_addr, erase_addr, prog_addr;
  int          erase_cnt, prog_cnt, err_total, checks, stall_cyc;

  flash_page_erase_row_program #(.ERASE_CYC(4), .PROG_CYC(3)) dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_stall(cpu_stall), .flash_erase(flash_erase),
    .flash_prog_wr(flash_prog_wr), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata));

  flash_array_model flash (
    .clk(clk), .rstn(rstn), .flash_erase(flash_erase),
    .flash_prog_wr(flash_prog_wr), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .erase_cnt(erase_cnt),
    .prog_cnt(prog_cnt), .erase_addr(erase_addr),
    .prog_addr(prog_addr), .prog_data(prog_data));

  // free-running clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // stall length counter
  always @(posedge clk) begin
    if (cpu_stall === 1'b1) stall_cyc++;
  end

  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  task automatic unlock;
    wr(`OFS_FLASH_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_FLASH_UNLOCK_KEY, `KEY_SECOND);
  endtask : unlock

  // control write with start, then stall length within lo..hi
  task automatic go(input logic [15:0] c, input int lo, input int hi);
    int n;
    n = 0;
    #1 stall_cyc = 0;
    wr(`OFS_FLASH_OP_CONTROL, c);
    repeat (2) @(posedge clk);
    if (lo > 0) rd(`OFS_FLASH_OP_CONTROL, c);
    while (cpu_stall !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, n, 0);
      final_report();
    end
    chk(24'(stall_cyc >= lo && stall_cyc <= hi), 24'h1);
    rd(`OFS_FLASH_OP_CONTROL, c & 16'h7fff);
  endtask : go

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    err_total = 0;
    checks = 0;
    stall_cyc = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(`OFS_FLASH_OP_CONTROL, `CTL_RESET);
    rd(`OFS_FLASH_UNLOCK_KEY, 16'h0000);
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
    go(16'hc042, 0, 0);
    wr(`OFS_FLASH_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_FLASH_UNLOCK_KEY, 16'h0011);
    wr(`OFS_FLASH_UNLOCK_KEY, `KEY_SECOND);
    go(16'hc042, 0, 0);
    wr(`OFS_TABLE_PAGE_POINTER, 16'h0012);
    wr(`OFS_TARGET_OFFSET, 16'h0345);
    unlock();
    go(16'hc041, 0, 0);
    unlock();
    go(16'h8042, 0, 0);
    chk(24'(erase_cnt), 24'h0);
    unlock();
    go(16'hc042, 4, 8);
    chk(24'(erase_cnt), 24'h1);
    chk(erase_addr, 24'h120200);
    // restore two rows, advancing the offset each time
    for (int r = 0; r < 2; r++) begin
      wr(`OFS_TARGET_OFFSET, 16'(16'h0345 + r * 64));
      for (int i = 0; i < 64; i++) begin
        wr(`OFS_ROW_BUFFER, 16'(16'h1000 + r * 256 + i));
      end
      unlock();
      go(16'hc001, 67, 72);
      chk(24'(prog_cnt), 24'(64 * (r + 1)));
      chk(prog_addr, 24'(24'h12037f + r * 64));
      chk({8'h00, prog_data}, 24'(24'h103f + r * 256));
      rd(`OFS_ROW_BUFFER, 16'h0000);
    end
    chk(24'(erase_cnt), 24'h1);
    final_report();
  end
endmodule : flash_page_erase_row_program_tb

`default_nettype wire
